// ---- rtl/sbp_pkg.sv ----
// Package of constants and types for the servo basic-setting parameter bank
package sbp_pkg;
	// Object indices; byte address is four times the index
	localparam logic [15:0] IDX_MODEL  = 16'h2000;
	localparam logic [15:0] IDX_KIND   = 16'h2001;
	localparam logic [15:0] IDX_CPR    = 16'h2002;
	localparam logic [15:0] IDX_NODE   = 16'h2003;
	localparam logic [15:0] IDX_DIR    = 16'h2004;
	localparam logic [15:0] IDX_TURN   = 16'h2005;
	localparam logic [15:0] IDX_PFTIME = 16'h2007;
	localparam logic [15:0] IDX_CTRL   = 16'h2010;
	localparam logic [15:0] IDX_STATUS = 16'h2011;
	// Reset values; model default is arbitrary
	localparam logic [15:0] RST_MODEL  = 16'h0001;
	localparam logic [15:0] RST_KIND   = 16'h0001;
	localparam logic [31:0] RST_CPR    = 32'h00080000;
	localparam logic [15:0] RST_NODE   = 16'h0001;
	localparam logic [15:0] RST_DIR    = 16'h0000;
	localparam logic [15:0] RST_TURN   = 16'h0001;
	localparam logic [15:0] RST_PFTIME = 16'h0014;
	// Setting ranges
	localparam logic [15:0] MODEL_MAX  = 16'h270f;
	localparam logic [15:0] KIND_MAX   = 16'h0002;
	localparam logic [31:0] CPR_MAX    = 32'h40000000;
	localparam logic [15:0] NODE_MAX   = 16'h0063;
	localparam logic [15:0] DIR_MAX    = 16'h0001;
	localparam logic [15:0] TURN_MAX   = 16'h0002;
	localparam logic [15:0] PFTIME_MAX = 16'h1388;
	localparam logic [31:0] CPR_ABS    = 32'h00080000;
	// Field positions
	localparam int CTRL_RESTART_BIT = 0;
	localparam int STAT_READY_BIT   = 0;
	localparam int STAT_DET_BIT     = 1;
	localparam int STAT_KIND_LSB    = 2;
	localparam int STAT_LOSS_BIT    = 4;
	// Encoder kinds
	localparam logic [15:0] KIND_QUAD   = 16'h0000;
	localparam logic [15:0] KIND_MULTI  = 16'h0001;
	localparam logic [15:0] KIND_SINGLE = 16'h0002;
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS         = 1000000;
	localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_INIT = 3'b001,
		ST_LOAD = 3'b010,
		ST_RUN  = 3'b100
	} sbp_st_e;

	typedef struct packed {
		sbp_st_e     st;
		logic [15:0] model;
		logic [15:0] kind;
		logic [31:0] cpr;
		logic [15:0] node;
		logic [15:0] dir;
		logic [15:0] turn;
		logic [15:0] pfTime;
		logic [15:0] aModel;
		logic [15:0] aKind;
		logic [31:0] aCpr;
		logic [15:0] aNode;
		logic        aDirCw;
		logic [47:0] pos;
		logic        decodeEn;
		logic [16:0] msCnt;
		logic [15:0] lossMs;
		logic        phaseLoss;
		logic        dphWr;
		logic        dphRd;
		logic [15:0] dphIdx;
		logic [31:0] hrdata;
		logic        hreadyout;
	} sbp_state_s;
endpackage : sbp_pkg

// ---- rtl/sbp_param_bank.sv ----
// Basic-setting parameter bank with AHB-Lite slave and restart-class latching
`timescale 1ns/100ps
module sbp_param_bank
	import sbp_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYCLES_DEF
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        encDetected,
	input  wire logic [1:0]  encDetKind,
	input  wire logic [15:0] motorIdAuto,
	input  wire logic [31:0] encSingleTurn,
	input  wire logic [15:0] encMultiTurn,
	input  wire logic        fbStep,
	input  wire logic        supplyLow,
	input  wire logic        restartReq,
	output logic      [15:0] activeModel,
	output logic      [15:0] activeKind,
	output logic      [31:0] activeCpr,
	output logic      [15:0] activeNode,
	output logic             dirClockwise,
	output logic      [47:0] posActual,
	output logic             decodeEn,
	output logic             phaseLoss
);
	sbp_state_s  s_r;
	sbp_state_s  s_nxt;
	logic [15:0] effKind;
	logic        isAbs;
	logic        accept;
	logic [15:0] aIdx;
	logic        aMapped;
	logic        restart;
	logic        inRange;

	// Detected serial encoder overrides the written kind
	assign effKind = encDetected ? {14'h0000, encDetKind} : s_r.kind;
	assign isAbs   = (effKind == KIND_MULTI) || (effKind == KIND_SINGLE);
	assign accept  = hsel && htrans[1] && hready;
	assign aIdx    = haddr[17:2];
	assign aMapped = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'b00);
	assign restart = restartReq ||
		(s_r.dphWr && s_r.dphIdx == IDX_CTRL && hwdata[CTRL_RESTART_BIT]);

	// Setting-range check of the value in the write data phase
	always_comb begin
		unique case (s_r.dphIdx)
			IDX_MODEL:  inRange = hwdata[31:16] == 16'h0000 && hwdata[15:0] != 16'h0000
				&& hwdata[15:0] <= MODEL_MAX;
			IDX_KIND:   inRange = hwdata[31:16] == 16'h0000 && hwdata[15:0] <= KIND_MAX;
			IDX_CPR:    inRange = hwdata != 32'h00000000 && hwdata <= CPR_MAX;
			IDX_NODE:   inRange = hwdata[31:16] == 16'h0000 && hwdata[15:0] != 16'h0000
				&& hwdata[15:0] <= NODE_MAX;
			IDX_DIR:    inRange = hwdata[31:16] == 16'h0000 && hwdata[15:0] <= DIR_MAX;
			IDX_TURN:   inRange = hwdata[31:16] == 16'h0000 && hwdata[15:0] <= TURN_MAX;
			IDX_PFTIME: inRange = hwdata[31:16] == 16'h0000 && hwdata[15:0] <= PFTIME_MAX;
			default:    inRange = 1'b0;
		endcase
	end

	always_comb begin
		s_nxt = s_r;
		// Bus: writes zero-wait, reads one wait state
		s_nxt.hreadyout = 1'b1;
		s_nxt.dphWr = 1'b0;
		if (s_r.dphWr && inRange) begin
			unique case (s_r.dphIdx)
				IDX_MODEL:  s_nxt.model  = hwdata[15:0];
				IDX_KIND:   s_nxt.kind   = hwdata[15:0];
				IDX_CPR:    s_nxt.cpr    = hwdata;
				IDX_NODE:   s_nxt.node   = hwdata[15:0];
				IDX_DIR:    s_nxt.dir    = hwdata[15:0];
				IDX_TURN:   s_nxt.turn   = hwdata[15:0];
				IDX_PFTIME: s_nxt.pfTime = hwdata[15:0];
				default:    s_nxt.pfTime = s_r.pfTime;
			endcase
		end
		if (s_r.dphRd) begin
			s_nxt.dphRd = 1'b0;
			s_nxt.hrdata = 32'h00000000;
			unique case (s_r.dphIdx)
				IDX_MODEL:  s_nxt.hrdata = {16'h0000, s_r.model};
				IDX_KIND:   s_nxt.hrdata = {16'h0000, s_r.kind};
				IDX_CPR:    s_nxt.hrdata = isAbs ? CPR_ABS : s_r.cpr;
				IDX_NODE:   s_nxt.hrdata = {16'h0000, s_r.node};
				IDX_DIR:    s_nxt.hrdata = {16'h0000, s_r.dir};
				IDX_TURN:   s_nxt.hrdata = {16'h0000, s_r.turn};
				IDX_PFTIME: s_nxt.hrdata = {16'h0000, s_r.pfTime};
				IDX_STATUS: begin
					s_nxt.hrdata[STAT_READY_BIT] = s_r.decodeEn;
					s_nxt.hrdata[STAT_DET_BIT]   = encDetected;
					s_nxt.hrdata[STAT_KIND_LSB+:2] = effKind[1:0];
					s_nxt.hrdata[STAT_LOSS_BIT]  = s_r.phaseLoss;
				end
				default:    s_nxt.hrdata = 32'h00000000;
			endcase
		end else if (accept) begin
			s_nxt.dphIdx = aMapped ? aIdx : 16'hffff;
			s_nxt.dphWr = hwrite;
			s_nxt.dphRd = !hwrite;
			s_nxt.hreadyout = hwrite;
		end

		// Active copy only changes in the load state
		unique case (s_r.st)
			ST_INIT: s_nxt.st = ST_LOAD;
			ST_LOAD: begin
				s_nxt.aKind  = effKind;
				s_nxt.aModel = isAbs ? motorIdAuto : s_r.model;
				s_nxt.aCpr   = isAbs ? CPR_ABS : s_r.cpr;
				s_nxt.aNode  = s_r.node;
				s_nxt.aDirCw = s_r.dir[0];
				s_nxt.pos    = 48'h000000000000;
				if (s_r.turn == 16'h0000 && effKind == KIND_MULTI) begin
					s_nxt.pos = {encMultiTurn, encSingleTurn};
				end else if (s_r.turn == 16'h0002 && effKind == KIND_MULTI) begin
					s_nxt.pos = {16'h0000, encSingleTurn};
				end
				s_nxt.st = ST_RUN;
			end
			ST_RUN: begin
				if (fbStep) begin
					s_nxt.pos = s_r.pos + 48'h000000000001;
				end
			end
		endcase
		if (restart) begin
			s_nxt.st = ST_LOAD;
		end
		s_nxt.decodeEn = (s_nxt.st == ST_RUN);

		// Supply-loss observation in whole milliseconds
		if (!supplyLow) begin
			s_nxt.msCnt = 17'h00000;
			s_nxt.lossMs = 16'h0000;
			s_nxt.phaseLoss = 1'b0;
		end else if (s_r.lossMs >= s_r.pfTime) begin
			s_nxt.phaseLoss = 1'b1;
		end else if (s_r.msCnt == 17'(MS_CYCLES - 1)) begin
			s_nxt.msCnt = 17'h00000;
			s_nxt.lossMs = s_r.lossMs + 16'h0001;
		end else begin
			s_nxt.msCnt = s_r.msCnt + 17'h00001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_r <= '{st: ST_INIT, model: RST_MODEL, kind: RST_KIND, cpr: RST_CPR,
				node: RST_NODE, dir: RST_DIR, turn: RST_TURN, pfTime: RST_PFTIME,
				aModel: RST_MODEL, aKind: RST_KIND, aCpr: RST_CPR, aNode: RST_NODE,
				aDirCw: 1'b0, pos: 48'h000000000000, decodeEn: 1'b0, msCnt: 17'h00000,
				lossMs: 16'h0000, phaseLoss: 1'b0, dphWr: 1'b0, dphRd: 1'b0,
				dphIdx: 16'h0000, hrdata: 32'h00000000, hreadyout: 1'b1};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign hrdata       = s_r.hrdata;
	assign hreadyout    = s_r.hreadyout;
	assign hresp        = 1'b0;
	assign activeModel  = s_r.aModel;
	assign activeKind   = s_r.aKind;
	assign activeCpr    = s_r.aCpr;
	assign activeNode   = s_r.aNode;
	assign dirClockwise = s_r.aDirCw;
	assign posActual    = s_r.pos;
	assign decodeEn     = s_r.decodeEn;
	assign phaseLoss    = s_r.phaseLoss;

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_node_reject: assert property (s_r.dphWr && s_r.dphIdx == IDX_NODE && hwdata > 32'h63
		|=> $stable(s_r.node)) else $error("node took out-of-range value");
	a_node_hold: assert property ($changed(activeNode) |-> $past(s_r.st) == ST_LOAD)
		else $error("active node changed outside restart");
	a_model_hold: assert property ($changed(activeModel) |-> $past(s_r.st) == ST_LOAD)
		else $error("active model changed outside restart");
	a_load_first: assert property ($rose(decodeEn) |-> $past(s_r.st) == ST_LOAD)
		else $error("decoding enabled without load");
	a_kind_stored: assert property (s_r.kind <= KIND_MAX)
		else $error("stored kind out of range");
	a_abs_counts: assert property (s_r.st == ST_LOAD && isAbs |=> activeCpr == CPR_ABS)
		else $error("absolute counts not loaded");
	a_turn_clear: assert property (s_r.st == ST_LOAD && s_r.turn == 16'h0001 && !restart
		|=> posActual == 48'h0) else $error("position not cleared");
	a_dir_latch: assert property (s_r.st == ST_LOAD |=> dirClockwise == $past(s_r.dir[0]))
		else $error("direction not latched");
	a_pos_up: assert property (s_r.st == ST_RUN && fbStep && !restart
		|=> posActual == $past(posActual) + 48'h1) else $error("feedback not upward");
	a_read_wait: assert property (accept && !hwrite && !s_r.dphRd |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_loss_cause: assert property ($rose(phaseLoss) |-> $past(supplyLow)
		&& $past(s_r.lossMs) >= $past(s_r.pfTime)) else $error("loss without drop");
	a_loss_clear: assert property (!supplyLow
		|=> !phaseLoss)
		else $error("loss kept after supply returned");
	a_pftime_range: assert property (s_r.pfTime <= PFTIME_MAX
		&& 1'b1)
		else $error("stored check interval out of range");

	// Range rejection per parameter
	a_model_reject: assert property (s_r.dphWr && s_r.dphIdx == IDX_MODEL
		&& (hwdata == 32'h00000000 || hwdata > {16'h0000, MODEL_MAX})
		|=> $stable(s_r.model)) else $error("model took out-of-range value");
	a_kind_reject: assert property (s_r.dphWr && s_r.dphIdx == IDX_KIND
		&& hwdata > {16'h0000, KIND_MAX}
		|=> $stable(s_r.kind)) else $error("kind took out-of-range value");
	a_cpr_reject: assert property (s_r.dphWr && s_r.dphIdx == IDX_CPR
		&& (hwdata == 32'h00000000 || hwdata > CPR_MAX)
		|=> $stable(s_r.cpr)) else $error("counts took out-of-range value");
	a_dir_reject: assert property (s_r.dphWr && s_r.dphIdx == IDX_DIR
		&& hwdata > {16'h0000, DIR_MAX}
		|=> $stable(s_r.dir)) else $error("direction took out-of-range value");
	a_turn_reject: assert property (s_r.dphWr && s_r.dphIdx == IDX_TURN
		&& hwdata > {16'h0000, TURN_MAX}
		|=> $stable(s_r.turn)) else $error("turn mode took out-of-range value");
	a_pftime_reject: assert property (s_r.dphWr && s_r.dphIdx == IDX_PFTIME
		&& hwdata > {16'h0000, PFTIME_MAX}
		|=> $stable(s_r.pfTime)) else $error("interval took out-of-range value");
	a_model_range: assert property (s_r.model != 16'h0000
		&& s_r.model <= MODEL_MAX)
		else $error("stored model out of range");
	a_node_range: assert property (s_r.node != 16'h0000
		&& s_r.node <= NODE_MAX)
		else $error("stored node out of range");
	a_cpr_range: assert property (s_r.cpr != 32'h00000000
		&& s_r.cpr <= CPR_MAX)
		else $error("stored counts out of range");

	// Immediate class and software restart
	a_pftime_now: assert property (s_r.dphWr && s_r.dphIdx == IDX_PFTIME
		&& hwdata <= {16'h0000, PFTIME_MAX}
		|=> s_r.pfTime == $past(hwdata[15:0])) else $error("interval not applied at once");
	a_ctrl_restart: assert property (s_r.dphWr && s_r.dphIdx == IDX_CTRL
		&& hwdata[CTRL_RESTART_BIT]
		|=> s_r.st == ST_LOAD) else $error("control restart not taken");

	// Load of the active copy
	a_turn_multi: assert property (s_r.st == ST_LOAD && s_r.turn == 16'h0000
		&& effKind == KIND_MULTI
		|=> posActual == $past({encMultiTurn, encSingleTurn})) else $error("multi-turn lost");
	a_turn_single: assert property (s_r.st == ST_LOAD && s_r.turn == 16'h0002
		&& effKind == KIND_MULTI
		|=> posActual == {16'h0000, $past(encSingleTurn)}) else $error("single-turn wrong");
	a_model_auto: assert property (s_r.st == ST_LOAD && isAbs
		|=> activeModel == $past(motorIdAuto))
		else $error("absolute model not auto-recognised");
	a_model_direct: assert property (s_r.st == ST_LOAD && !isAbs
		|=> activeModel == $past(s_r.model))
		else $error("incremental model not taken from register");
	a_counts_direct: assert property (s_r.st == ST_LOAD && !isAbs
		|=> activeCpr == $past(s_r.cpr))
		else $error("incremental counts not taken from register");
	a_kind_load: assert property (s_r.st == ST_LOAD
		|=> activeKind == $past(effKind))
		else $error("active kind not loaded");
	a_node_load: assert property (s_r.st == ST_LOAD
		|=> activeNode == $past(s_r.node))
		else $error("active node not loaded");
	a_decode_state: assert property (decodeEn
		== (s_r.st == ST_RUN))
		else $error("decode enable outside run state");

	// Read-back and bus timing
	a_status_kind: assert property (s_r.dphRd && s_r.dphIdx == IDX_STATUS
		|=> hrdata[STAT_KIND_LSB+:2] == $past(effKind[1:0]))
		else $error("status kind wrong");
	a_counts_read: assert property (s_r.dphRd && s_r.dphIdx == IDX_CPR && isAbs
		|=> hrdata == CPR_ABS)
		else $error("absolute counts not read back");
	a_write_nowait: assert property (accept && hwrite
		|=> hreadyout)
		else $error("write wait state inserted");

	c_restart: cover property (restart ##1 s_r.st == ST_LOAD ##1 decodeEn);
	c_write_node: cover property (s_r.dphWr && s_r.dphIdx == IDX_NODE && inRange);
	c_phase_loss: cover property ($rose(phaseLoss));
	c_read: cover property (s_r.dphRd ##1 hreadyout);
	c_turn_multi: cover property (s_r.st == ST_LOAD && s_r.turn == 16'h0000 && effKind == KIND_MULTI);
endmodule : sbp_param_bank

// ---- verification/sbp_host_model.sv ----
// Host master model issuing single-word AHB-Lite transfers
`timescale 1ns/100ps
module sbp_host_model
	import sbp_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata
);
	initial begin
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// Address phase held until hready, then data phase until hready; byte address 4*index
	task automatic xfer(input logic [15:0] idx, input logic wr, input logic [31:0] wd,
		output logic [31:0] rd);
		haddr  <= {14'h0, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		@(posedge ref_clk);
		while (hready !== 1'b1) @(posedge ref_clk);
		htrans <= 2'b00;
		hwdata <= wr ? wd : ~hwdata;
		@(posedge ref_clk);
		while (hready !== 1'b1) @(posedge ref_clk);
		rd = hrdata;
	endtask : xfer
endmodule : sbp_host_model

// ---- verification/tb_sbp_param_bank.sv ----
// Self-checking bench for the basic-setting parameter bank
`timescale 1ns/100ps
module tb_sbp_param_bank import sbp_pkg::*;;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        hsel, hwrite, hready, hreadyout, hresp, encDetected, fbStep;
	logic        supplyLow, restartReq, dirClockwise, decodeEn, phaseLoss;
	logic [1:0]  htrans, encDetKind;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, encSingleTurn, activeCpr, rdv;
	logic [15:0] motorIdAuto, encMultiTurn, activeModel, activeKind, activeNode;
	logic [47:0] posActual;
	int          n_fail = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	int          n;
	logic [15:0] ix [9] = '{IDX_MODEL, IDX_KIND, IDX_CPR, IDX_NODE, IDX_DIR, IDX_TURN,
		IDX_PFTIME, 16'h2006, IDX_CTRL};
	logic [31:0] rv [9] = '{32'(RST_MODEL), 32'(RST_KIND), CPR_ABS, 32'(RST_NODE),
		32'(RST_DIR), 32'(RST_TURN), 32'(RST_PFTIME), 32'h0, 32'h0};
	logic [15:0] bi [10] = '{IDX_MODEL, IDX_MODEL, IDX_NODE, IDX_NODE, IDX_KIND, IDX_DIR,
		IDX_TURN, IDX_PFTIME, IDX_CPR, IDX_CPR};
	logic [31:0] bv [10] = '{32'h0, 32'h2710, 32'h0, 32'h64, 32'h3, 32'h2, 32'h3, 32'h1389,
		32'h0, 32'h40000001};
	logic [47:0] pe [3] = '{48'h0007_0001_2345, 48'h0, 48'h0000_0001_2345};

	localparam int MS_SIM    = 4;
	localparam int LOSS_CYC  = 2 * MS_SIM + 2;
	localparam int CYC_LIMIT = 2000;

	assign hready = hreadyout;
	always #5 ref_clk = ~ref_clk;

	sbp_param_bank #(
		.MS_CYCLES(MS_SIM)
	) i_dut (
		.ref_clk      (ref_clk),
		.rst          (rst),
		.hsel         (hsel),
		.haddr        (haddr),
		.htrans       (htrans),
		.hwrite       (hwrite),
		.hsize        (hsize),
		.hwdata       (hwdata),
		.hready       (hready),
		.hrdata       (hrdata),
		.hreadyout    (hreadyout),
		.hresp        (hresp),
		.encDetected  (encDetected),
		.encDetKind   (encDetKind),
		.motorIdAuto  (motorIdAuto),
		.encSingleTurn(encSingleTurn),
		.encMultiTurn (encMultiTurn),
		.fbStep       (fbStep),
		.supplyLow    (supplyLow),
		.restartReq   (restartReq),
		.activeModel  (activeModel),
		.activeKind   (activeKind),
		.activeCpr    (activeCpr),
		.activeNode   (activeNode),
		.dirClockwise (dirClockwise),
		.posActual    (posActual),
		.decodeEn     (decodeEn),
		.phaseLoss    (phaseLoss)
	);
	sbp_host_model i_host (
		.ref_clk(ref_clk),
		.hready (hready),
		.hrdata (hrdata),
		.hsel   (hsel),
		.haddr  (haddr),
		.htrans (htrans),
		.hwrite (hwrite),
		.hsize  (hsize),
		.hwdata (hwdata)
	);

	task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [15:0] idx, input logic [31:0] d);
		i_host.xfer(idx, 1'b1, d, rdv);
	endtask : wr
	task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
		i_host.xfer(idx, 1'b0, 32'h0, rdv);
		chk("read data", {16'h0, exp}, {16'h0, rdv});
		chk("response", 48'h0, {47'h0, hresp});
	endtask : rdc
	task automatic restart();
		restartReq <= 1'b1;
		@(posedge ref_clk);
		restartReq <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask : restart
	task automatic conclude();
		$display("Comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == CYC_LIMIT) begin
			n_fail++;
			conclude();
		end
	end

	initial begin
		encDetected = 1'b0;
		encDetKind = 2'b00;
		motorIdAuto = 16'h0042;
		encSingleTurn = 32'h0001_2345;
		encMultiTurn = 16'h0007;
		fbStep = 1'b0;
		supplyLow = 1'b0;
		restartReq = 1'b0;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		for (int k = 0; k < 9; k++) rdc(ix[k], rv[k]);
		for (int k = 0; k < 10; k++) wr(bi[k], bv[k]);
		for (int k = 0; k < 9; k++) rdc(ix[k], rv[k]);
		$display("Test reset and range done");
		wr(IDX_KIND, 32'h0);
		wr(IDX_MODEL, 32'h270f);
		wr(IDX_CPR, 32'h2000);
		wr(IDX_NODE, 32'h63);
		wr(IDX_DIR, 32'h1);
		chk("node before restart", 48'h1, 48'(activeNode));
		chk("model before restart", 48'h42, 48'(activeModel));
		chk("counts before restart", 48'(CPR_ABS), 48'(activeCpr));
		restart();
		chk("node", 48'h63, 48'(activeNode));
		chk("model", 48'h270f, 48'(activeModel));
		chk("counts", 48'h2000, 48'(activeCpr));
		chk("kind", 48'h0, 48'(activeKind));
		chk("direction", 48'h1, 48'(dirClockwise));
		chk("decode enable", 48'h1, 48'(decodeEn));
		fbStep <= 1'b1;
		repeat (3) @(posedge ref_clk);
		fbStep <= 1'b0;
		@(posedge ref_clk);
		chk("feedback count", 48'h3, posActual);
		$display("Test restart class done");
		wr(IDX_KIND, 32'h1);
		for (int t = 0; t < 3; t++) begin
			wr(IDX_TURN, 32'(t));
			restart();
			chk("position", pe[t], posActual);
		end
		chk("auto model", 48'h42, 48'(activeModel));
		$display("Test turn handling done");
		encDetected <= 1'b1;
		encDetKind <= 2'b10;
		@(posedge ref_clk);
		rdc(IDX_STATUS, 32'h0b);
		rdc(IDX_KIND, 32'h1);
		wr(IDX_NODE, 32'h5);
		chk("node held", 48'h63, 48'(activeNode));
		wr(IDX_CTRL, 32'h1);
		repeat (3) @(posedge ref_clk);
		chk("node after soft restart", 48'h5, 48'(activeNode));
		chk("model after soft restart", 48'h42, 48'(activeModel));
		chk("detected kind", 48'h2, 48'(activeKind));
		$display("Test detection done");
		wr(IDX_PFTIME, 32'h2);
		supplyLow <= 1'b1;
		for (n = 0; n < 30 && phaseLoss !== 1'b1; n++) @(posedge ref_clk);
		chk("loss delay", 48'(LOSS_CYC), 48'(n));
		supplyLow <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk("loss cleared", 48'h0, 48'(phaseLoss));
		$display("Test supply loss done");
		conclude();
	end
endmodule : tb_sbp_param_bank
